/* File: shared/amps_consts.vh */
`ifndef AMPS_CONSTS_VH
`define AMPS_CONSTS_VH

// ----------------------------------------------------------------------
// Control port and timing
// ----------------------------------------------------------------------
`define AMPS_DEV_ADDR       7'h38
`define AMPS_CLK_MHZ        100
`define AMPS_LOAD_TIME_US   1000

// ----------------------------------------------------------------------
// Register offsets, page zero except UNLOCK and OCP on the locked page
// ----------------------------------------------------------------------
`define AMPS_REG_PAGE       7'h00
`define AMPS_REG_SWRST      7'h01
`define AMPS_REG_PLAY       7'h02
`define AMPS_REG_PMODE      7'h03
`define AMPS_REG_RATE       7'h08
`define AMPS_REG_WORD       7'h0A
`define AMPS_REG_RXSLOT     7'h0C
`define AMPS_REG_TXCFG      7'h0D
`define AMPS_REG_VSNS       7'h0E
`define AMPS_REG_ISNS       7'h0F
`define AMPS_REG_AUDTX      7'h16
`define AMPS_REG_UVLO       7'h71
`define AMPS_REG_BOOK       7'h7F
`define AMPS_REG_UNLOCK     7'h0D
`define AMPS_REG_OCP        7'h3B

// ----------------------------------------------------------------------
// Pages, keys, field positions, reset values
// ----------------------------------------------------------------------
`define AMPS_PAGE_ZERO      8'h00
`define AMPS_PAGE_LOCKED    8'hFD
`define AMPS_KEY_OPEN       8'h0D
`define AMPS_KEY_CLOSE      8'h00
`define AMPS_SWRST_BIT      0
`define AMPS_PLAY_MSB       1
`define AMPS_SEL_MSB        7
`define AMPS_SEL_LSB        6
`define AMPS_SLOT_EN_BIT    6
`define AMPS_PLAY_RST       8'h02
`define AMPS_PMODE_RST      8'hA8
`define AMPS_OCP_RST        8'h01

// ----------------------------------------------------------------------
// Output supply select codes and power states
// ----------------------------------------------------------------------
`define AMPS_SEL_MODE0      2'b10
`define AMPS_SEL_MODE1      2'b00
`define AMPS_SEL_MODE2      2'b11
`define AMPS_SEL_MODE3      2'b01
`define AMPS_PS_HWSD        2'b00
`define AMPS_PS_SWSD        2'b01
`define AMPS_PS_ACTIVE      2'b10

`endif

/* File: hw/amps_seq.v */
`include "amps_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module amps_seq #(
    parameter LOAD_CYCLES = `AMPS_LOAD_TIME_US * `AMPS_CLK_MHZ
) (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       nrst,
    // Pins from outside the clock domain
    input  wire       shutdown_n_pin,
    input  wire       scl_in,
    input  wire       sda_in,
    input  wire       rail_headroom_low,
    input  wire       signal_above_threshold,
    // Open-drain data line
    output wire       sda_out,
    output reg        sda_oe,
    // Power state
    output reg  [1:0] power_state,
    output reg        config_loading,
    // Supply control
    output reg  [1:0] output_supply_select,
    output reg        low_rail_source_internal,
    output reg        output_on_high_rail,
    output reg        low_rail_discharge,
    output reg  [5:0] high_rail_undervoltage_threshold,
    // Serial audio configuration and overcurrent trim
    output reg        vsense_tx_en,
    output reg  [5:0] vsense_tx_slot,
    output reg        isense_tx_en,
    output reg  [5:0] isense_tx_slot,
    output reg        audio_tx_en,
    output reg  [5:0] audio_tx_slot,
    output reg  [7:0] rate_cfg,
    output reg  [7:0] word_cfg,
    output reg  [7:0] rx_slot_cfg,
    output reg  [7:0] tx_cfg,
    output reg  [7:0] ocp_trim
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam [16:0] LOAD_CNT = LOAD_CYCLES[16:0];

    reg  [4:0] sync1_q;
    reg  [4:0] sync2_q;
    reg        scl_p_q;
    reg        sda_p_q;
    reg        sdz_p_q;

    wire sdz_s  = sync2_q[0];
    wire scl_s  = sync2_q[1];
    wire sda_s  = sync2_q[2];
    wire head_s = sync2_q[3];
    wire sig_s  = sync2_q[4];

    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            sync1_q <= 5'h06;
            sync2_q <= 5'h06;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sdz_p_q <= 1'b0;
        end
        else
        begin
            sync1_q <= {signal_above_threshold, rail_headroom_low, sda_in, scl_in,
                        shutdown_n_pin};
            sync2_q <= sync1_q;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            sdz_p_q <= sdz_s;
        end
    end

    wire i2c_start = scl_s & sda_p_q & ~sda_s;
    wire i2c_stop  = scl_s & ~sda_p_q & sda_s;
    wire scl_rise  = scl_s & ~scl_p_q;
    wire scl_fall  = ~scl_s & scl_p_q;
    wire sdz_rise  = sdz_s & ~sdz_p_q;

    assign sda_out = 1'b0;

    // ------------------------------------------------------------------
    // Register storage and read path
    // ------------------------------------------------------------------
    reg  [7:0] r0_q [0:127];
    reg  [7:0] rfd_q [0:127];
    reg  [7:0] page_q;
    reg  [7:0] book_q;
    reg        unlock_q;
    reg  [16:0] load_q;

    reg  [2:0] st_q;
    reg  [2:0] bc_q;
    reg  [7:0] sh_q;
    reg  [6:0] ptr_q;
    reg        rw_q;
    reg        ack_q;
    reg        ph_q;
    reg        first_q;

    wire       loading = (load_q != 17'h00000);
    wire [7:0] rx_byte = {sh_q[6:0], sda_s};

    reg  [7:0] rd_byte;
    always @*
    begin
        rd_byte = 8'h00;
        if (ptr_q == `AMPS_REG_PAGE)
            rd_byte = page_q;
        else if (book_q == `AMPS_PAGE_ZERO && page_q == `AMPS_PAGE_ZERO)
        begin
            if (ptr_q == `AMPS_REG_BOOK)
                rd_byte = book_q;
            else
                rd_byte = r0_q[ptr_q];
        end
        else if (book_q == `AMPS_PAGE_ZERO && page_q == `AMPS_PAGE_LOCKED)
        begin
            if (ptr_q == `AMPS_REG_UNLOCK)
                rd_byte = {4'h0, unlock_q, 1'b0, unlock_q, 1'b0} ^ 8'h00;
            else if (unlock_q)
                rd_byte = rfd_q[ptr_q];
        end
    end

    // ------------------------------------------------------------------
    // Control port, register writes and reset sequencing
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_DATA = 3'd2;
    localparam [2:0] ST_ACK  = 3'd3;
    localparam [2:0] ST_RD   = 3'd4;
    localparam [2:0] ST_RACK = 3'd5;

    // Low shutdown pin holds registers, load counter and control port in reset; rising pin or soft reset reloads.
    wire hw_hold = ~sdz_s;
    wire wr_ok   = (st_q == ST_DATA) & scl_rise & (bc_q == 3'd7) & ~first_q;
    wire swrst   = wr_ok & (page_q == `AMPS_PAGE_ZERO) & (book_q == `AMPS_PAGE_ZERO)
                   & (ptr_q == `AMPS_REG_SWRST) & rx_byte[`AMPS_SWRST_BIT];
    wire cfg_rst = hw_hold | swrst;

    integer i;
    always @(posedge sys_clk)
    begin
        if (!nrst || cfg_rst)
        begin
            for (i = 0; i < 128; i = i + 1)
            begin
                r0_q[i]  <= 8'h00;
                rfd_q[i] <= 8'h00;
            end
            r0_q[`AMPS_REG_PLAY]  <= `AMPS_PLAY_RST;
            r0_q[`AMPS_REG_PMODE] <= `AMPS_PMODE_RST;
            rfd_q[`AMPS_REG_OCP]  <= `AMPS_OCP_RST;
            page_q   <= 8'h00;
            book_q   <= 8'h00;
            unlock_q <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (ptr_q == `AMPS_REG_PAGE)
                page_q <= rx_byte;
            else if (book_q != `AMPS_PAGE_ZERO)
                book_q <= book_q;
            else if (page_q == `AMPS_PAGE_ZERO)
            begin
                if (ptr_q == `AMPS_REG_BOOK)
                    book_q <= rx_byte;
                else if (ptr_q != `AMPS_REG_SWRST)
                    r0_q[ptr_q] <= rx_byte;
            end
            else if (page_q == `AMPS_PAGE_LOCKED)
            begin
                if (ptr_q == `AMPS_REG_UNLOCK)
                begin
                    if (rx_byte == `AMPS_KEY_OPEN)
                        unlock_q <= 1'b1;
                    else if (rx_byte == `AMPS_KEY_CLOSE)
                        unlock_q <= 1'b0;
                end
                else if (unlock_q)
                    rfd_q[ptr_q] <= rx_byte;
            end
        end
    end

    // Configuration memory load window after any reset.
    always @(posedge sys_clk)
    begin
        if (!nrst)
            load_q <= LOAD_CNT;
        else if (hw_hold)
            load_q <= 17'h00000;
        else if (sdz_rise || swrst)
            load_q <= LOAD_CNT;
        else if (loading)
            load_q <= load_q - 17'h00001;
    end

    always @(posedge sys_clk)
    begin
        if (!nrst || hw_hold)
        begin
            st_q    <= ST_IDLE;
            bc_q    <= 3'd0;
            sh_q    <= 8'h00;
            ptr_q   <= 7'h00;
            rw_q    <= 1'b0;
            ack_q   <= 1'b0;
            ph_q    <= 1'b0;
            first_q <= 1'b1;
            sda_oe  <= 1'b0;
        end
        else if (i2c_start)
        begin
            st_q   <= ST_ADDR;
            bc_q   <= 3'd0;
            sda_oe <= 1'b0;
        end
        else if (i2c_stop)
        begin
            st_q   <= ST_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (st_q)
            ST_ADDR, ST_DATA:
            begin
                if (scl_rise)
                begin
                    sh_q <= rx_byte;
                    bc_q <= bc_q + 3'd1;
                    if (bc_q == 3'd7)
                    begin
                        st_q <= ST_ACK;
                        ph_q <= 1'b0;
                        if (st_q == ST_ADDR)
                        begin
                            // No answer while configuration memory loads.
                            ack_q   <= (rx_byte[7:1] == `AMPS_DEV_ADDR) & ~loading;
                            rw_q    <= rx_byte[0];
                            first_q <= ~rx_byte[0];
                        end
                        else
                        begin
                            ack_q   <= 1'b1;
                            first_q <= 1'b0;
                            if (first_q)
                                ptr_q <= rx_byte[6:0];
                            else
                                ptr_q <= ptr_q + 7'd1;
                        end
                    end
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    if (!ph_q)
                    begin
                        sda_oe <= ack_q;
                        ph_q   <= 1'b1;
                    end
                    else if (!ack_q)
                    begin
                        sda_oe <= 1'b0;
                        st_q   <= ST_IDLE;
                    end
                    else if (rw_q)
                    begin
                        st_q   <= ST_RD;
                        bc_q   <= 3'd0;
                        sh_q   <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                    end
                    else
                    begin
                        sda_oe <= 1'b0;
                        st_q   <= ST_DATA;
                        bc_q   <= 3'd0;
                    end
                end
            end
            ST_RD:
            begin
                if (scl_rise)
                begin
                    bc_q <= bc_q + 3'd1;
                    if (bc_q == 3'd7)
                    begin
                        st_q  <= ST_RACK;
                        ptr_q <= ptr_q + 7'd1;
                    end
                end
                else if (scl_fall)
                    sda_oe <= ~sh_q[3'd7 - bc_q];
            end
            ST_RACK:
            begin
                if (scl_fall)
                    sda_oe <= 1'b0;
                else if (scl_rise)
                begin
                    bc_q <= 3'd0;
                    sh_q <= rd_byte;
                    if (sda_s)
                        st_q <= ST_IDLE;
                    else
                        st_q <= ST_RD;
                end
            end
            default:
                st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Power state and supply path
    // ------------------------------------------------------------------
    wire [7:0] play_r  = r0_q[`AMPS_REG_PLAY];
    wire [1:0] sel     = r0_q[`AMPS_REG_PMODE][`AMPS_SEL_MSB:`AMPS_SEL_LSB];
    wire       play_on = (play_r[`AMPS_PLAY_MSB:0] == 2'b00) & ~loading;

    reg  [1:0] ps_d;
    reg        high_d;
    always @*
    begin
        if (hw_hold)
            ps_d = `AMPS_PS_HWSD;
        else if (play_on)
            ps_d = `AMPS_PS_ACTIVE;
        else
            ps_d = `AMPS_PS_SWSD;
        case (sel)
        `AMPS_SEL_MODE0: high_d = 1'b1;
        `AMPS_SEL_MODE1: high_d = head_s | sig_s;
        `AMPS_SEL_MODE2: high_d = sig_s;
        `AMPS_SEL_MODE3: high_d = 1'b0;
        default:         high_d = 1'b1;
        endcase
    end

    // Rail and slot outputs are registered so no decode glitch reaches pins.
    always @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            power_state              <= `AMPS_PS_HWSD;
            config_loading           <= 1'b0;
            output_supply_select     <= 2'b00;
            low_rail_source_internal <= 1'b0;
            output_on_high_rail      <= 1'b0;
            low_rail_discharge       <= 1'b0;
            high_rail_undervoltage_threshold <= 6'h00;
            vsense_tx_en   <= 1'b0;
            vsense_tx_slot <= 6'h00;
            isense_tx_en   <= 1'b0;
            isense_tx_slot <= 6'h00;
            audio_tx_en    <= 1'b0;
            audio_tx_slot  <= 6'h00;
            rate_cfg       <= 8'h00;
            word_cfg       <= 8'h00;
            rx_slot_cfg    <= 8'h00;
            tx_cfg         <= 8'h00;
            ocp_trim       <= 8'h00;
        end
        else
        begin
            power_state              <= ps_d;
            config_loading           <= loading;
            output_supply_select     <= sel;
            low_rail_source_internal <= (sel == `AMPS_SEL_MODE2) & ~hw_hold;
            output_on_high_rail      <= (ps_d == `AMPS_PS_ACTIVE) & high_d;
            // The internal low rail bleeds down only from software shutdown.
            low_rail_discharge <= (sel == `AMPS_SEL_MODE2)
                                  & (ps_d == `AMPS_PS_SWSD);
            high_rail_undervoltage_threshold <= r0_q[`AMPS_REG_UVLO][5:0];
            vsense_tx_en   <= r0_q[`AMPS_REG_VSNS][`AMPS_SLOT_EN_BIT];
            vsense_tx_slot <= r0_q[`AMPS_REG_VSNS][5:0];
            isense_tx_en   <= r0_q[`AMPS_REG_ISNS][`AMPS_SLOT_EN_BIT];
            isense_tx_slot <= r0_q[`AMPS_REG_ISNS][5:0];
            audio_tx_en    <= r0_q[`AMPS_REG_AUDTX][`AMPS_SLOT_EN_BIT];
            audio_tx_slot  <= r0_q[`AMPS_REG_AUDTX][5:0];
            rate_cfg       <= r0_q[`AMPS_REG_RATE];
            word_cfg       <= r0_q[`AMPS_REG_WORD];
            rx_slot_cfg    <= r0_q[`AMPS_REG_RXSLOT];
            tx_cfg         <= r0_q[`AMPS_REG_TXCFG];
            ocp_trim       <= rfd_q[`AMPS_REG_OCP];
        end
    end

endmodule // amps_seq

`default_nettype wire

/* File: tb/amps_seq_props.sv */
`timescale 1ns/1ps
`default_nettype none

module amps_seq_props #(
    parameter LOAD_CYCLES = 100000
) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Pins
    input wire logic       shutdown_n_pin,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       rail_headroom_low,
    input wire logic       signal_above_threshold,
    // Observed outputs
    input wire logic [1:0] power_state,
    input wire logic       config_loading,
    input wire logic [1:0] output_supply_select,
    input wire logic       low_rail_source_internal,
    input wire logic       output_on_high_rail,
    input wire logic [7:0] tx_cfg
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------------
    // Pin inputs pass a two-stage synchroniser, so antecedents span its lag.
    hw_shutdown_a: assert property (!shutdown_n_pin [*4] |-> power_state == 2'b00)
        else $error("power state not cleared by shutdown pin");
    sw_entry_a: assert property ($rose(shutdown_n_pin) ##1 shutdown_n_pin [*5] |-> power_state == 2'b01)
        else $error("shutdown pin release did not give software shutdown");
    load_hold_a: assert property (config_loading [*2] |-> power_state != 2'b10)
        else $error("active while loading");

    // ------------------------------------------------------------------
    // Supply selection
    // ------------------------------------------------------------------
    idle_rail_a: assert property ((power_state != 2'b10) [*2] |-> !output_on_high_rail)
        else $error("high rail used while not active");
    mode0_high_a: assert property ((output_supply_select == 2'b10 && power_state == 2'b10) [*2]
        |-> output_on_high_rail)
        else $error("mode 0 not on high rail");
    mode3_low_a: assert property ((output_supply_select == 2'b01) [*2] |-> !output_on_high_rail)
        else $error("mode 3 left the low rail");
    headroom_high_a: assert property ((output_supply_select == 2'b00 && power_state == 2'b10
        && rail_headroom_low) [*5] |-> output_on_high_rail)
        else $error("low headroom did not hold the high rail");
    quiet_ldo_a: assert property ((output_supply_select == 2'b11 && !signal_above_threshold) [*5]
        |-> !output_on_high_rail)
        else $error("mode 2 quiet signal on high rail");
    ldo_select_a: assert property ((output_supply_select != 2'b11) [*2] |-> !low_rail_source_internal)
        else $error("internal low rail outside mode 2");
    idle_stable_a: assert property ((scl_in && sda_in && shutdown_n_pin) [*8] |-> $stable(tx_cfg))
        else $error("config changed with the bus idle");

    cover property ($fell(config_loading));
endmodule // amps_seq_props

bind amps_seq amps_seq_props #(.LOAD_CYCLES(LOAD_CYCLES)) amps_seq_props_i (
    .sys_clk(sys_clk), .nrst(nrst), .shutdown_n_pin(shutdown_n_pin), .scl_in(scl_in),
    .sda_in(sda_in), .rail_headroom_low(rail_headroom_low),
    .signal_above_threshold(signal_above_threshold), .power_state(power_state),
    .config_loading(config_loading), .output_supply_select(output_supply_select),
    .low_rail_source_internal(low_rail_source_internal),
    .output_on_high_rail(output_on_high_rail), .tx_cfg(tx_cfg)
);
`default_nettype wire

/* File: tb/amps_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "amps_consts.vh"

module amps_host (
    // Clock
    input  wire logic sys_clk,
    // Resolved data line
    input  wire logic sda_in,
    // Host drives
    output var logic  scl,
    output var logic  sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input integer n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Data moves mid low phase; the answer is taken just before SCL falls.
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        tick(2);
        scl = 1'b1;
        tick(4);
        r = sda_in;
        scl = 1'b0;
        tick(2);
    endtask

    task automatic start;
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask

    // SCL stays high after a stop, so the link clock stands still between frames.
    task automatic stop;
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(8);
    endtask

    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic byte_in(output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(1'b1, r);
    endtask

    task automatic wr(input logic [7:0] o, input logic [7:0] v, output logic ok);
        logic a0, a1, a2;
        start;
        byte_out({`AMPS_DEV_ADDR, 1'b0}, a0);
        byte_out(o, a1);
        byte_out(v, a2);
        stop;
        ok = a0 & a1 & a2;
    endtask

    task automatic rd(input logic [7:0] o, output logic [7:0] v, output logic ok);
        logic a0, a1, a2;
        start;
        byte_out({`AMPS_DEV_ADDR, 1'b0}, a0);
        byte_out(o, a1);
        start;
        byte_out({`AMPS_DEV_ADDR, 1'b1}, a2);
        byte_in(v);
        stop;
        ok = a0 & a1 & a2;
    endtask
endmodule // amps_host
`default_nettype wire

/* File: tb/amps_seq_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module amps_seq_bench;
    localparam logic [63:0] T_OFF = 64'h0E0F080A0C0D7116;
    localparam logic [63:0] T_VAL = 64'h4440390A203303C0;
    localparam logic [31:0] M_VAL = 32'hA828E868;
    localparam logic [31:0] M_PLAY = 32'h80008000;
    logic       sys_clk, nrst, shutdown_n_pin, rail_headroom_low, signal_above_threshold;
    wire        scl, sda_low, sda_line, sda_out, sda_oe, config_loading;
    wire        low_rail_source_internal, output_on_high_rail, low_rail_discharge;
    wire        vsense_tx_en, isense_tx_en, audio_tx_en;
    wire  [1:0] power_state, output_supply_select;
    wire  [5:0] high_rail_undervoltage_threshold, vsense_tx_slot, isense_tx_slot, audio_tx_slot;
    wire  [7:0] rate_cfg, word_cfg, rx_slot_cfg, tx_cfg, ocp_trim, pstat;
    integer     n_fail, total_checks, i, k;
    logic       ok, er;
    logic [7:0] d, mv;

    // Open-drain data line with a pull-up.
    assign sda_line = ~((sda_oe & ~sda_out) | sda_low);
    assign pstat = {power_state, output_supply_select, low_rail_source_internal,
                    output_on_high_rail, low_rail_discharge, 1'b0};

    amps_host amps_host_i (.sys_clk(sys_clk), .sda_in(sda_line), .scl(scl), .sda_low(sda_low));

    amps_seq #(.LOAD_CYCLES(200)) amps_seq_i (
        .sys_clk(sys_clk), .nrst(nrst), .shutdown_n_pin(shutdown_n_pin), .scl_in(scl),
        .sda_in(sda_line), .rail_headroom_low(rail_headroom_low),
        .signal_above_threshold(signal_above_threshold), .sda_out(sda_out), .sda_oe(sda_oe),
        .power_state(power_state), .config_loading(config_loading),
        .output_supply_select(output_supply_select),
        .low_rail_source_internal(low_rail_source_internal),
        .output_on_high_rail(output_on_high_rail), .low_rail_discharge(low_rail_discharge),
        .high_rail_undervoltage_threshold(high_rail_undervoltage_threshold),
        .vsense_tx_en(vsense_tx_en), .vsense_tx_slot(vsense_tx_slot),
        .isense_tx_en(isense_tx_en), .isense_tx_slot(isense_tx_slot),
        .audio_tx_en(audio_tx_en), .audio_tx_slot(audio_tx_slot), .rate_cfg(rate_cfg),
        .word_cfg(word_cfg), .rx_slot_cfg(rx_slot_cfg), .tx_cfg(tx_cfg), .ocp_trim(ocp_trim)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic w(input logic [7:0] o, input logic [7:0] v);
        amps_host_i.wr(o, v, ok);
        chk({7'h00, ok}, 8'h01);
    endtask

    task automatic r(input logic [7:0] o, input logic [7:0] e);
        amps_host_i.rd(o, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, e);
    endtask

    // The host must stay quiet until the configuration load is over.
    task automatic wait_load;
        for (k = 0; k < 400 && config_loading !== 1'b0; k++)
            @(negedge sys_clk);
        if (config_loading !== 1'b0)
        begin
            chk(8'h01, 8'h00);
            give_verdict;
        end
        repeat (4) @(negedge sys_clk);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        shutdown_n_pin = 1'b0;
        rail_headroom_low = 1'b0;
        signal_above_threshold = 1'b0;
        n_fail = 0;
        total_checks = 0;
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk({6'h00, power_state}, 8'h00);
        shutdown_n_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk({5'h00, config_loading, power_state}, 8'h05);
        amps_host_i.wr(8'h03, 8'h68, ok);
        chk({7'h00, ok}, 8'h00);
        wait_load;
        r(8'h03, 8'hA8);
        r(8'h02, 8'h02);
        r(8'h50, 8'h00);
        for (i = 0; i < 8; i++)
        begin
            w(T_OFF[8*(7-i) +: 8], T_VAL[8*(7-i) +: 8]);
            r(T_OFF[8*(7-i) +: 8], T_VAL[8*(7-i) +: 8]);
        end
        chk({1'b0, vsense_tx_en, vsense_tx_slot}, 8'h44);
        chk({1'b0, isense_tx_en, isense_tx_slot}, 8'h40);
        chk({1'b0, audio_tx_en, audio_tx_slot}, 8'h40);
        chk(rate_cfg, 8'h39);
        chk(word_cfg, 8'h0A);
        chk(rx_slot_cfg, 8'h20);
        chk(tx_cfg, 8'h33);
        chk({2'b00, high_rail_undervoltage_threshold}, 8'h03);
        w(8'h71, 8'h0E);
        chk({2'b00, high_rail_undervoltage_threshold}, 8'h0E);
        w(8'h0E, 8'h00);
        w(8'h0F, 8'h00);
        chk({vsense_tx_en, isense_tx_en, 6'h00}, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            mv = M_VAL[8*(3-i) +: 8];
            w(8'h03, mv);
            w(8'h02, M_PLAY[8*(3-i) +: 8]);
            for (k = 0; k < 4; k++)
            begin
                rail_headroom_low = k[0];
                signal_above_threshold = k[1];
                repeat (6) @(negedge sys_clk);
                er = (i == 0) || (i == 1 && k != 0) || (i == 2 && k >= 2);
                chk(pstat, {2'b10, mv[7:6], mv[7:6] == 2'b11, er, 2'b00});
            end
            rail_headroom_low = 1'b0;
            signal_above_threshold = 1'b0;
            w(8'h02, 8'h02);
            chk(pstat, {2'b01, mv[7:6], mv[7:6] == 2'b11, 1'b0, mv[7:6] == 2'b11, 1'b0});
        end
        w(8'h00, 8'hFD);
        w(8'h3B, 8'h55);
        chk(ocp_trim, 8'h01);
        w(8'h0D, 8'h0D);
        r(8'h3B, 8'h01);
        w(8'h3B, 8'h0F);
        chk(ocp_trim, 8'h0F);
        w(8'h0D, 8'h00);
        w(8'h3B, 8'h55);
        chk(ocp_trim, 8'h0F);
        w(8'h00, 8'h01);
        w(8'h03, 8'hA8);
        w(8'h00, 8'h00);
        chk({6'h00, output_supply_select}, 8'h01);
        w(8'h01, 8'h01);
        chk({7'h00, config_loading}, 8'h01);
        chk(tx_cfg, 8'h00);
        amps_host_i.wr(8'h02, 8'h80, ok);
        chk({7'h00, ok}, 8'h00);
        wait_load;
        r(8'h03, 8'hA8);
        r(8'h01, 8'h00);
        w(8'h0D, 8'h33);
        w(8'h7F, 8'h01);
        w(8'h0D, 8'h11);
        chk(tx_cfg, 8'h33);
        shutdown_n_pin = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk({tx_cfg[5:0], power_state}, 8'h00);
        shutdown_n_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk({5'h00, config_loading, power_state}, 8'h05);
        wait_load;
        give_verdict;
    end
endmodule // amps_seq_bench
`default_nettype wire
